// File: ctsg_regs.svh
// register offsets, field layouts and reset values for the core tick select and clock gating block
`ifndef CTSG_REGS_SVH
`define CTSG_REGS_SVH
`define CTSG_ADDR_TICK_SOURCE 16'hE220
`define CTSG_ADDR_CLOCK_GATE  16'hE280
`define CTSG_TICK_SOURCE_RST  16'h0000
`define CTSG_CLOCK_GATE_RST   16'h0000
`define CTSG_SEL_MASK         16'h001F
`define CTSG_GATE_MASK        16'h01FF
`define CTSG_SEL_NORMAL       5'h00
`define CTSG_SEL_DUAL         5'h01
`define CTSG_SEL_QUAD         5'h02
`define CTSG_SEL_IN_FIRST     5'h03
`define CTSG_SEL_IN_LAST      5'h0E
`define CTSG_SEL_OUT_FIRST    5'h0F
`define CTSG_SEL_OUT_LAST     5'h1A
`define CTSG_SEL_SPDIF        5'h1B
`define CTSG_MCLK_DIV         6'h3F
`define CTSG_CORE_MULT        8'h37
`define CTSG_QUAD_FIRST       8'h0D
`define CTSG_DUAL_MID         8'h1B
`define CTSG_QUAD_THIRD       8'h29
`endif

// File: ctsg_pkg.sv
// types shared by the core tick select block
package ctsg_pkg;
  typedef enum logic [3:0] {
    CTSG_SRC_INTERNAL = 4'h1,
    CTSG_SRC_SERIN    = 4'h2,
    CTSG_SRC_SEROUT   = 4'h4,
    CTSG_SRC_SPDIF    = 4'h8
  } ctsg_src_t;
endpackage

// File: ctsg_sync.sv
// two flop synchroniser per bit with rising edge pulse out
`timescale 1ns/100ps
`default_nettype none
module ctsg_sync #(
  parameter int WIDTH = 25
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] risePulse
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_rise;
  always_comb begin
    next_rise = stage2 & ~stage3;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1    <= '0;
      stage2    <= '0;
      stage3    <= '0;
      risePulse <= '0;
    end else begin
      stage1    <= asyncIn;
      stage2    <= stage1;
      stage3    <= stage2;
      risePulse <= next_rise;
    end
  end
endmodule
`default_nettype wire

// File: ctsg_top.sv
// core start pulse select and subsystem master clock gating
`timescale 1ns/100ps
`default_nettype none
`include "ctsg_regs.svh"
module ctsg_top #(
  parameter int PAIRS = 12
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  input  wire logic [15:0]      regAddr,
  input  wire logic [15:0]      regWdata,
  output logic      [15:0]      regRdata,
  input  wire logic [PAIRS-1:0] serialInFrameClk,
  input  wire logic [PAIRS-1:0] serialOutFrameClk,
  input  wire logic             spdifFrameClk,
  output logic                  coreStartPulse,
  output logic      [8:0]       subsystemClockEnable,
  output logic      [3:0]       startSourceKind
);
  logic [4:0]            tickSelect;
  logic [8:0]            clockGate;
  logic [4:0]            next_tickSelect;
  logic [8:0]            next_clockGate;
  logic [15:0]           next_rdata;
  logic [2*PAIRS:0]      frameRise;
  logic [5:0]            mclkCount;
  logic [7:0]            multCount;
  logic [5:0]            next_mclkCount;
  logic [7:0]            next_multCount;
  logic                  normalTick;
  logic                  dualTick;
  logic                  quadTick;
  logic                  next_start;
  ctsg_pkg::ctsg_src_t   next_kind;

  // external frame clocks come from other domains
  ctsg_sync #(.WIDTH(2*PAIRS+1)) frameSync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .asyncIn   ({spdifFrameClk, serialOutFrameClk, serialInFrameClk}),
    .risePulse (frameRise)
  );

  // register file: only the documented field bits are stored
  always_comb begin
    next_tickSelect = tickSelect;
    next_clockGate  = clockGate;
    if (regWrite && regAddr == `CTSG_ADDR_TICK_SOURCE) begin
      next_tickSelect = regWdata[4:0];
    end
    if (regWrite && regAddr == `CTSG_ADDR_CLOCK_GATE) begin
      next_clockGate = regWdata[8:0];
    end
    next_rdata = regRdata;
    if (regRead) begin
      unique case (regAddr)
        `CTSG_ADDR_TICK_SOURCE: next_rdata = {11'h000, tickSelect} & `CTSG_SEL_MASK;
        `CTSG_ADDR_CLOCK_GATE:  next_rdata = {7'h00, clockGate} & `CTSG_GATE_MASK;
        default:                next_rdata = 16'h0000;
      endcase
    end
  end

  // normal tick: 56 periods of the 64 x fs clock; a single counter pair spans 3584 cycles
  always_comb begin
    next_mclkCount = mclkCount + 6'h01;
    next_multCount = multCount;
    normalTick     = 1'b0;
    if (mclkCount == `CTSG_MCLK_DIV) begin
      next_mclkCount = 6'h00;
      next_multCount = multCount + 8'h01;
      if (multCount == `CTSG_CORE_MULT) begin
        next_multCount = 8'h00;
      end
    end
    // dual ticks at half, quad at quarter of the 56 period frame
    // all three ticks share one counter so switching rate never skews the frame
    dualTick = (mclkCount == `CTSG_MCLK_DIV) &&
               (multCount == `CTSG_DUAL_MID || multCount == `CTSG_CORE_MULT);
    quadTick = (mclkCount == `CTSG_MCLK_DIV) &&
               (multCount == `CTSG_QUAD_FIRST || multCount == `CTSG_DUAL_MID ||
                multCount == `CTSG_QUAD_THIRD || multCount == `CTSG_CORE_MULT);
    normalTick = (mclkCount == `CTSG_MCLK_DIV) && (multCount == `CTSG_CORE_MULT);
  end

  // start pulse mux
  always_comb begin
    next_start = normalTick;
    next_kind  = ctsg_pkg::CTSG_SRC_INTERNAL;
    if (tickSelect == `CTSG_SEL_NORMAL) begin
      next_start = normalTick;
    end else if (tickSelect == `CTSG_SEL_DUAL) begin
      next_start = dualTick;
    end else if (tickSelect == `CTSG_SEL_QUAD) begin
      next_start = quadTick;
    end else if (tickSelect <= `CTSG_SEL_IN_LAST) begin
      next_start = frameRise[5'(tickSelect - `CTSG_SEL_IN_FIRST)];
      next_kind  = ctsg_pkg::CTSG_SRC_SERIN;
    end else if (tickSelect <= `CTSG_SEL_OUT_LAST) begin
      next_start = frameRise[5'(tickSelect - `CTSG_SEL_OUT_FIRST) + 5'(PAIRS)];
      next_kind  = ctsg_pkg::CTSG_SRC_SEROUT;
    end else if (tickSelect == `CTSG_SEL_SPDIF) begin
      next_start = frameRise[2*PAIRS];
      next_kind  = ctsg_pkg::CTSG_SRC_SPDIF;
    end
  end

  // register file state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickSelect           <= `CTSG_SEL_NORMAL;
      clockGate            <= 9'h000;
      regRdata             <= 16'h0000;
    end else begin
      tickSelect           <= next_tickSelect;
      clockGate            <= next_clockGate;
      regRdata             <= next_rdata;
    end
  end

  // internal rate counters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mclkCount            <= 6'h00;
      multCount            <= 8'h00;
    end else begin
      mclkCount            <= next_mclkCount;
      multCount            <= next_multCount;
    end
  end

  // outputs: enables follow the write edge itself, not a cycle later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreStartPulse       <= 1'b0;
      subsystemClockEnable <= 9'h000;
      startSourceKind      <= ctsg_pkg::CTSG_SRC_INTERNAL;
    end else begin
      coreStartPulse       <= next_start;
      subsystemClockEnable <= next_clockGate;
      startSourceKind      <= next_kind;
    end
  end
endmodule
`default_nettype wire

// File: ctsg_top_asserts.sv
// port checker for the core tick select and clock gating block
`timescale 1ns/100ps
`default_nettype none
`include "ctsg_regs.svh"
module ctsg_top_asserts #(
  parameter int PAIRS = 12
) (
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             regWrite,
  input wire logic             regRead,
  input wire logic [15:0]      regAddr,
  input wire logic [15:0]      regWdata,
  input wire logic [15:0]      regRdata,
  input wire logic [PAIRS-1:0] serialInFrameClk,
  input wire logic [PAIRS-1:0] serialOutFrameClk,
  input wire logic             spdifFrameClk,
  input wire logic             coreStartPulse,
  input wire logic [8:0]       subsystemClockEnable,
  input wire logic [3:0]       startSourceKind
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire gateHit = regAddr == `CTSG_ADDR_CLOCK_GATE;
  wire tickHit = regAddr == `CTSG_ADDR_TICK_SOURCE;
  sequence spdifEdge;
    startSourceKind == 4'h8 && $rose(spdifFrameClk);
  endsequence
  gate_write_a: assert property (regWrite && gateHit |=> subsystemClockEnable == $past(regWdata[8:0]))
    else $error("gate enables differ from written value");
  gate_hold_a: assert property (!(regWrite && gateHit) |=> $stable(subsystemClockEnable))
    else $error("gate enables moved without a write");
  gate_read_a: assert property (regRead && gateHit |=> regRdata == {7'h00, $past(subsystemClockEnable)})
    else $error("gate readback wrong");
  tick_reserved_a: assert property (regRead && tickHit |=> regRdata[15:5] == 11'h000)
    else $error("tick select reserved bits not zero");
  unmapped_read_a: assert property (regRead && !gateHit && !tickHit |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  source_onehot_a: assert property ($onehot(startSourceKind))
    else $error("source kind not one-hot");
  pulse_single_a: assert property (coreStartPulse |=> !coreStartPulse)
    else $error("start pulse longer than one cycle");
  spdif_start_a: assert property (spdifEdge |-> ##[2:6] coreStartPulse)
    else $error("no start pulse after receiver frame edge");
endmodule
bind ctsg_top ctsg_top_asserts #(.PAIRS(PAIRS)) ctsg_top_asserts_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .serialInFrameClk(serialInFrameClk), .serialOutFrameClk(serialOutFrameClk), .spdifFrameClk(spdifFrameClk),
  .coreStartPulse(coreStartPulse), .subsystemClockEnable(subsystemClockEnable), .startSourceKind(startSourceKind));
`default_nettype wire

// File: tb_ctsg_top.sv
// self-checking bench for the core tick select and clock gating block
`timescale 1ns/100ps
`default_nettype none
`include "ctsg_regs.svh"
module tb_ctsg_top;
  logic        sysClk = 1'b0;
  logic        rstN = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [11:0] inFc = 12'h000;
  logic [11:0] outFc = 12'h000;
  logic        spFc = 1'b0;
  logic        pulse;
  logic [8:0]  clkEn;
  logic [3:0]  kind;
  int          miscompares = 0;
  int          total_checks = 0;
  int          n;
  logic [47:0] rows [5] = '{48'hE280_FFFF_01FF, 48'hE280_0021_0021, 48'hE220_FFFF_001F,
                            48'hE220_001B_001B, 48'h1234_FFFF_0000};
  logic [4:0]  tickCode [5] = '{5'h00, 5'h01, 5'h02, 5'h1C, 5'h1F};
  int          tickGap [5] = '{3584, 1792, 896, 3584, 3584};
  always #2 sysClk = ~sysClk;
  ctsg_top ctsg_top_i (.sys_clk(sysClk), .rst_n(rstN), .regWrite(wr), .regRead(rd), .regAddr(addr),
    .regWdata(wdata), .regRdata(rdata), .serialInFrameClk(inFc), .serialOutFrameClk(outFc),
    .spdifFrameClk(spFc), .coreStartPulse(pulse), .subsystemClockEnable(clkEn), .startSourceKind(kind));
  task automatic chk(input logic ok);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: value mismatch", $time);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge sysClk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge sysClk);
    wr = 1'b0;
    rd = 1'b0;
  endtask
  // a pulse stands one cycle, so sampling on every falling edge cannot miss it
  task automatic waitP(input int lim);
    n = 0;
    while (pulse !== 1'b1 && n < lim) begin
      @(negedge sysClk);
      n++;
    end
  endtask
  // other frame clocks rise first, so a source mux that ORs its inputs is caught
  task automatic frame(input logic [4:0] code, input logic [3:0] k, input int bitPos);
    acc(1'b1, `CTSG_ADDR_TICK_SOURCE, {11'h000, code});
    repeat (8) @(negedge sysClk);
    chk(kind === k);
    {spFc, outFc, inFc} = ~(25'h0000001 << bitPos);
    waitP(10);
    chk(n == 10);
    {spFc, outFc, inFc} = '1;
    waitP(10);
    chk(n < 10);
    repeat (6) @(negedge sysClk);
    {spFc, outFc, inFc} = '0;
  endtask
  task automatic final_report();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge sysClk);
    rstN = 1'b1;
    chk(clkEn === 9'h000 && kind === 4'h1);
    acc(1'b0, `CTSG_ADDR_TICK_SOURCE, 16'h0000);
    chk(rdata === `CTSG_TICK_SOURCE_RST);
    acc(1'b0, `CTSG_ADDR_CLOCK_GATE, 16'h0000);
    chk(rdata === `CTSG_CLOCK_GATE_RST);
    foreach (rows[i]) begin
      acc(1'b1, rows[i][47:32], rows[i][31:16]);
      acc(1'b0, rows[i][47:32], 16'h0000);
      chk(rdata === rows[i][15:0]);
    end
    acc(1'b0, `CTSG_ADDR_CLOCK_GATE, 16'h0000);
    chk(rdata === 16'h0021 && clkEn === 9'h021);
    for (int i = 0; i < 12; i++) begin
      frame(5'(3 + i), 4'h2, i);
      frame(5'(15 + i), 4'h4, 12 + i);
    end
    frame(5'h1B, 4'h8, 24);
    foreach (tickCode[i]) begin
      acc(1'b1, `CTSG_ADDR_TICK_SOURCE, {11'h000, tickCode[i]});
      waitP(4000);
      @(negedge sysClk);
      waitP(4000);
      chk(n + 1 == tickGap[i] && kind === 4'h1);
    end
    // reset in mid-run must bring both registers back to their defaults
    acc(1'b1, `CTSG_ADDR_TICK_SOURCE, 16'h001B);
    @(negedge sysClk);
    rstN = 1'b0;
    repeat (2) @(negedge sysClk);
    rstN = 1'b1;
    chk(clkEn === 9'h000 && kind === 4'h1 && pulse === 1'b0);
    acc(1'b0, `CTSG_ADDR_TICK_SOURCE, 16'h0000);
    chk(rdata === `CTSG_TICK_SOURCE_RST);
    final_report();
  end
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
